// ==== fifo_thresh_map.svh ====
// register map, field positions and decode levels of the fifo threshold control
`ifndef FIFO_THRESH_MAP_SVH
`define FIFO_THRESH_MAP_SVH

`define OFF_FIFO_CONTROL  8'h00
`define OFF_IRQ_STATUS    8'h04
`define OFF_IRQ_CLEAR     8'h08
`define OFF_IRQ_ENABLE    8'h0c
`define OFF_LINK_STATUS   8'h10

`define FIFO_CONTROL_RST  16'h0000
`define FIFO_CONTROL_MASK 16'h07ff
`define CH2_CONTROL_MASK  16'h00f7
`define IRQ_RST           2'h0

`define POS_LOOPBACK      0
`define POS_RX_FIFO_RST   1
`define POS_TX_FIFO_RST   2
`define POS_MODEM_EN      3
`define POS_RX_TRIG_LO    6
`define POS_RX_TRIG_HI    7
`define POS_FLOW_LO       8
`define POS_FLOW_HI       10

`define IRQ_BIT_RDF       0
`define IRQ_BIT_RTS       1

`define FLOW_LVL_0        5'h0f
`define FLOW_LVL_1        5'h01
`define FLOW_LVL_2        5'h04
`define FLOW_LVL_3        5'h06
`define FLOW_LVL_4        5'h08
`define FLOW_LVL_5        5'h0a
`define FLOW_LVL_6        5'h0c
`define FLOW_LVL_7        5'h0e

`define ASYNC_LVL_0       5'h01
`define ASYNC_LVL_1       5'h04
`define ASYNC_LVL_2       5'h08
`define ASYNC_LVL_3       5'h0e
`define SYNC_LVL_1        5'h02

`endif

// ==== fifo_thresh_pkg.sv ====
// types of the fifo threshold control
package fifo_thresh_pkg;

  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_READ  = 2'b01,
    PH_WRITE = 2'b10
  } bus_phase_t;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [1:0]  irq_status;
    logic [1:0]  irq_enable;
    logic        rts;
    logic        cts_n;
    logic        irq;
    bus_phase_t  phase;
    logic [7:0]  addr;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } ctl_state_t;

endpackage : fifo_thresh_pkg

// ==== remote_peer.sv ====
// remote serial peer: fills the receive fifo count and drives clear-to-send
`timescale 1ns/1ps
module remote_peer (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // fill target and readiness
  input  wire logic [4:0] i_target,
  input  wire logic       i_ready_n,
  // channel side
  output logic      [4:0] o_count,
  output logic            o_cts_n
);
  // one entry a cycle toward the target, as frames arrive or are read
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) o_count <= 5'h00;
    else if (o_count < i_target) o_count <= o_count + 5'h01;
    else if (o_count > i_target) o_count <= o_count - 5'h01;
  end
  assign o_cts_n = i_ready_n;
endmodule : remote_peer

// ==== serial_fifo_threshold_control.sv ====
// fifo control register, flow-control and receive-full logic behind an ahb-lite slave
//
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "fifo_thresh_map.svh"

// What this block does
// - The control register is 16 bits wide and clears to zero on reset.
// - Software may read and write the control register at any time.
// - Bits 15 to 11 read as zero and software writes only zero there.
// - Request-to-send goes high once the receive count exceeds the flow level.
// - Flow field codes 000..111 select 15, 1, 4, 6, 8, 10, 12 and 14 entries.
// - On channel 2 the flow field is reserved, reads zero and is written zero.
// - The receive-full flag sets when the receive count exceeds the trigger level.
// - In asynchronous mode trigger codes 00..11 select 1, 4, 8 and 14 entries.
// - In synchronous mode trigger codes 00..11 select 1, 2, 8 and 14 entries.
// - The register holds transmit and receive fifo resets and a loop-back enable.
// - With modem control off, o_cts_active_n is held active while link status reads raw i_cts_n, and request-to-send is low.
module serial_fifo_threshold_control
  import fifo_thresh_pkg::*;
#(
  parameter int COUNT_W  = 5,
  parameter bit CHANNEL2 = 1'b0
) (
  // clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_rst_n,
  // ahb-lite slave
  input  wire logic               i_hsel,
  input  wire logic [31:0]        i_haddr,
  input  wire logic [1:0]         i_htrans,
  input  wire logic               i_hwrite,
  input  wire logic [2:0]         i_hsize,
  input  wire logic [31:0]        i_hwdata,
  input  wire logic               i_hready,
  output logic                    o_hreadyout,
  output logic [31:0]             o_hrdata,
  output logic                    o_hresp,
  // channel side
  input  wire logic [COUNT_W-1:0] i_rx_count,
  input  wire logic               i_sync_mode,
  input  wire logic               i_cts_n,
  output logic                    o_cts_active_n,
  output logic                    o_rts,
  output logic                    o_tx_fifo_reset,
  output logic                    o_rx_fifo_reset,
  output logic                    o_loopback,
  output logic [1:0]              o_tx_trigger,
  // interrupt
  output logic                    o_irq
);

  localparam logic [15:0] WMASK = CHANNEL2 ? `CH2_CONTROL_MASK : `FIFO_CONTROL_MASK;

  ctl_state_t cur_reg;
  ctl_state_t cur_next;
  logic       modem_control_enable;
  logic [1:0] events;
  logic [31:0] rd_val;

  thresh_if #(.COUNT_W(COUNT_W)) th ();

  threshold_compare #(.COUNT_W(COUNT_W)) u_cmp (
    .th (th)
  );

  assign th.rx_count  = i_rx_count;
  assign th.flow_sel  = cur_reg.ctrl[`POS_FLOW_HI:`POS_FLOW_LO];
  assign th.trig_sel  = cur_reg.ctrl[`POS_RX_TRIG_HI:`POS_RX_TRIG_LO];
  assign th.sync_mode = i_sync_mode;
  assign modem_control_enable          = cur_reg.ctrl[`POS_MODEM_EN];

  always_comb begin
    cur_next = cur_reg;
    rd_val   = 32'h0000_0000;
    // data phase of a write
    if (cur_reg.phase == PH_WRITE) begin
      if (cur_reg.addr == `OFF_FIFO_CONTROL) begin
        cur_next.ctrl = i_hwdata[15:0] & WMASK;
      end else if (cur_reg.addr == `OFF_IRQ_CLEAR) begin
        cur_next.irq_status = cur_reg.irq_status & ~i_hwdata[1:0];
      end else if (cur_reg.addr == `OFF_IRQ_ENABLE) begin
        cur_next.irq_enable = i_hwdata[1:0];
      end
    end
    // flow control and modem gating
    cur_next.rts   = modem_control_enable & th.over_flow;
    cur_next.cts_n = modem_control_enable ? i_cts_n : 1'b0;
    // sticky events, set beats clear
    events[`IRQ_BIT_RDF] = th.over_trig;
    events[`IRQ_BIT_RTS] = cur_next.rts & ~cur_reg.rts;
    cur_next.irq_status  = cur_next.irq_status | events;
    cur_next.irq         = |(cur_reg.irq_status & cur_reg.irq_enable);
    // address phase
    cur_next.hreadyout = 1'b1;
    cur_next.hresp     = 1'b0;
    cur_next.phase     = PH_IDLE;
    if (i_hsel && i_htrans[1] && i_hready) begin
      cur_next.phase = i_hwrite ? PH_WRITE : PH_READ;
      cur_next.addr  = i_haddr[7:0];
      if (i_haddr[7:0] == `OFF_FIFO_CONTROL) begin
        rd_val = {16'h0000, cur_next.ctrl};
      end else if (i_haddr[7:0] == `OFF_IRQ_STATUS) begin
        rd_val = {30'h0000_0000, cur_next.irq_status};
      end else if (i_haddr[7:0] == `OFF_IRQ_ENABLE) begin
        rd_val = {30'h0000_0000, cur_next.irq_enable};
      end else if (i_haddr[7:0] == `OFF_LINK_STATUS) begin
        rd_val = {22'h00_0000, i_cts_n, cur_reg.rts, th.over_trig, th.over_flow,
                  (6 - COUNT_W)'(0), i_rx_count};
      end
    end
    cur_next.hrdata = rd_val;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cur_reg            <= '0;
      cur_reg.ctrl       <= `FIFO_CONTROL_RST;
      cur_reg.irq_status <= `IRQ_RST;
      cur_reg.irq_enable <= `IRQ_RST;
      cur_reg.hreadyout  <= 1'b1;
      cur_reg.phase      <= PH_IDLE;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign o_hreadyout     = cur_reg.hreadyout;
  assign o_hrdata        = cur_reg.hrdata;
  assign o_hresp         = cur_reg.hresp;
  assign o_rts           = cur_reg.rts;
  assign o_cts_active_n  = cur_reg.cts_n;
  assign o_irq           = cur_reg.irq;
  assign o_tx_fifo_reset = cur_reg.ctrl[`POS_TX_FIFO_RST];
  assign o_rx_fifo_reset = cur_reg.ctrl[`POS_RX_FIFO_RST];
  assign o_loopback      = cur_reg.ctrl[`POS_LOOPBACK];
  assign o_tx_trigger    = cur_reg.ctrl[5:4];

  // helper: first cycle after reset release
  logic first_reg;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      first_reg <= 1'b1;
    end else begin
      first_reg <= 1'b0;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  reset_clear_a: assert property (first_reg |-> cur_reg.ctrl == 16'h0000)
    else $error("control register not zero after reset");

  ctrl_write_a: assert property (
    cur_reg.phase == PH_WRITE && cur_reg.addr == `OFF_FIFO_CONTROL
    |=> cur_reg.ctrl == ($past(i_hwdata[15:0]) & WMASK))
    else $error("control write not stored");

  rsvd_read_a: assert property (
    cur_reg.phase == PH_READ && cur_reg.addr == `OFF_FIFO_CONTROL
    |-> o_hrdata[31:11] == 21'h00_0000 && o_hreadyout)
    else $error("reserved control bits read nonzero");

  rts_rise_a: assert property (
    modem_control_enable && i_rx_count > 5'h0f && th.flow_sel == 3'h0 |=> o_rts)
    else $error("rts not raised above level 15");

  flow_decode_a: assert property (
    th.flow_sel == 3'h1 |-> th.over_flow == (i_rx_count > 5'h01))
    else $error("flow level code 001 not one entry");

  ch2_flow_a: assert property (CHANNEL2 |-> cur_reg.ctrl[10:8] == 3'h0 && !cur_reg.ctrl[3])
    else $error("channel 2 reserved bits set");

  rdf_set_a: assert property (
    th.over_trig |=> cur_reg.irq_status[`IRQ_BIT_RDF]
                     ##1 (o_irq || !$past(cur_reg.irq_enable[0])))
    else $error("receive full flag or interrupt missing");

  async_trig_a: assert property (
    !i_sync_mode && th.trig_sel == 2'h1 |-> th.over_trig == (i_rx_count > 5'h04))
    else $error("asynchronous trigger code 01 not four");

  sync_trig_a: assert property (
    i_sync_mode && th.trig_sel == 2'h1 |-> th.over_trig == (i_rx_count > 5'h02))
    else $error("synchronous trigger code 01 not two");

  loop_out_a: assert property (
    cur_reg.phase == PH_WRITE && cur_reg.addr == `OFF_FIFO_CONTROL
    |=> o_loopback == $past(i_hwdata[0]) && o_rx_fifo_reset == $past(i_hwdata[1]))
    else $error("loop-back or fifo reset not taken");

  modem_off_a: assert property (!modem_control_enable |=> !o_rts && !o_cts_active_n)
    else $error("modem signals not fixed while disabled");

  rts_fall_a: assert property (!th.over_flow |=> !o_rts)
    else $error("rts stays high at or below level");

  okay_resp_a: assert property (o_hreadyout && !o_hresp)
    else $error("bus stalled or error response");

  idle_data_a: assert property (cur_reg.phase == PH_IDLE |-> o_hrdata == 32'h0000_0000)
    else $error("read data outside a data phase");

  rsvd_zero_a: assert property (cur_reg.ctrl[15:11] == 5'h00)
    else $error("reserved control bits hold ones");

  flow_top_a: assert property (
    th.flow_sel == 3'h7 |-> th.over_flow == (i_rx_count > 5'h0e))
    else $error("flow level code 111 not fourteen entries");

  trig_top_a: assert property (
    th.trig_sel == 2'h3 |-> th.over_trig == (i_rx_count > 5'h0e))
    else $error("trigger code 11 not fourteen entries");

  irq_clear_a: assert property (
    cur_reg.phase == PH_WRITE && cur_reg.addr == `OFF_IRQ_CLEAR && i_hwdata[0]
    && !th.over_trig |=> !cur_reg.irq_status[`IRQ_BIT_RDF])
    else $error("receive full flag not cleared");

  cts_pass_a: assert property (modem_control_enable |=> o_cts_active_n == $past(i_cts_n))
    else $error("clear-to-send not passed while enabled");

  rts_seen_c:  cover property (modem_control_enable && th.over_flow ##1 o_rts ##[1:20] !o_rts);
  rdf_irq_c:   cover property (cur_reg.irq_enable[0] && th.over_trig ##2 o_irq);
  sync_trig_c: cover property (i_sync_mode && th.trig_sel == 2'h1 && th.over_trig);
  clr_race_c:  cover property (cur_reg.phase == PH_WRITE && cur_reg.addr == `OFF_IRQ_CLEAR
                               && th.over_trig);

endmodule : serial_fifo_threshold_control

// ==== tb.sv ====
// testbench: register, flow-control, trigger and interrupt scenarios
`timescale 1ns/1ps
`include "fifo_thresh_map.svh"
module tb;
  import fifo_thresh_pkg::*;
  logic        i_clk, i_rst_n, hsel, hwrite, sync_mode, ready_n;
  logic        hrdy, hresp, cts_act_n, rts, txr, rxr, lpb, irq, cts_n;
  logic [1:0]  htrans, tx_trig;
  logic [7:0]  haddr;
  logic [31:0] hwdata, hrdata, rd;
  logic [4:0]  target, count;
  int          error_cnt, num_checks, lv;
  int          flw[8] = '{15, 1, 4, 6, 8, 10, 12, 14};
  int          asy[4] = '{1, 4, 8, 14};
  int          syn[4] = '{1, 2, 8, 14};

  serial_fifo_threshold_control u_serial_fifo_threshold_control (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(hsel), .i_haddr({24'h0, haddr}),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hrdy), .o_hreadyout(hrdy), .o_hrdata(hrdata), .o_hresp(hresp),
    .i_rx_count(count), .i_sync_mode(sync_mode), .i_cts_n(cts_n),
    .o_cts_active_n(cts_act_n), .o_rts(rts), .o_tx_fifo_reset(txr),
    .o_rx_fifo_reset(rxr), .o_loopback(lpb), .o_tx_trigger(tx_trig), .o_irq(irq));
  remote_peer u_remote_peer (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_target(target),
    .i_ready_n(ready_n), .o_count(count), .o_cts_n(cts_n));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // wait for hready high, bounded
  task automatic rdy_wait;
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (hrdy !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      end_sim();
    end
  endtask : rdy_wait

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    rdy_wait();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    rdy_wait();
    q = hrdata;
  endtask : xfer

  task automatic fill(input int n);
    int k;
    target <= 5'(n);
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (count !== 5'(n) && k < 50);
    if (k >= 50) begin
      error_cnt++;
      end_sim();
    end
    repeat (2) @(posedge i_clk);
  endtask : fill

  initial begin
    i_rst_n = 1'b0; hsel = 1'b0; htrans = 2'h0; haddr = 8'h00; hwrite = 1'b0;
    hwdata = 32'h0; sync_mode = 1'b0; ready_n = 1'b1; target = 5'h00;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    xfer(1'b0, `OFF_FIFO_CONTROL, 32'h0, rd);
    chk("control reset", rd, 32'h0);
    xfer(1'b1, `OFF_FIFO_CONTROL, 32'h07ff, rd);
    xfer(1'b0, `OFF_FIFO_CONTROL, 32'h0, rd);
    chk("control written", rd, 32'h07ff);
    chk("okay response", hresp, 1'b0);
    chk("fifo resets loopback", {txr, rxr, lpb, tx_trig}, 5'h1f);
    xfer(1'b0, 8'h20, 32'h0, rd);
    chk("unmapped read", rd, 32'h0);
    $display("test register done");
    for (int c = 0; c < 8; c++) begin
      xfer(1'b1, `OFF_FIFO_CONTROL, (32'(c) << 8) | 32'h8, rd);
      fill(flw[c]);
      chk("rts at level", rts, 1'b0);
      fill(flw[c] + 1);
      chk("rts above level", rts, 1'b1);
    end
    xfer(1'b0, `OFF_LINK_STATUS, 32'h0, rd);
    chk("link status", rd, 32'h0000_03cf);
    xfer(1'b0, `OFF_IRQ_STATUS, 32'h0, rd);
    chk("status after rts", rd, 32'h0000_0003);
    chk("cts passed", cts_act_n, 1'b1);
    ready_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk("cts low passed", cts_act_n, 1'b0);
    ready_n <= 1'b1;
    xfer(1'b1, `OFF_FIFO_CONTROL, 32'h0700, rd);
    repeat (2) @(posedge i_clk);
    chk("rts modem off", rts, 1'b0);
    chk("cts forced", cts_act_n, 1'b0);
    $display("test flow control done");
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 4; c++) begin
        sync_mode <= m[0];
        lv = m ? syn[c] : asy[c];
        xfer(1'b1, `OFF_FIFO_CONTROL, 32'(c) << 6, rd);
        fill(lv);
        xfer(1'b1, `OFF_IRQ_CLEAR, 32'h3, rd);
        xfer(1'b0, `OFF_IRQ_STATUS, 32'h0, rd);
        chk("full at level", rd[0], 1'b0);
        fill(lv + 1);
        xfer(1'b0, `OFF_IRQ_STATUS, 32'h0, rd);
        chk("full above level", rd[0], 1'b1);
      end
    end
    $display("test trigger done");
    xfer(1'b1, `OFF_IRQ_ENABLE, 32'h1, rd);
    repeat (2) @(posedge i_clk);
    chk("irq enabled", irq, 1'b1);
    xfer(1'b1, `OFF_IRQ_ENABLE, 32'h0, rd);
    repeat (2) @(posedge i_clk);
    chk("irq masked", irq, 1'b0);
    xfer(1'b1, `OFF_IRQ_ENABLE, 32'h1, rd);
    fill(0);
    xfer(1'b1, `OFF_IRQ_CLEAR, 32'h1, rd);
    repeat (2) @(posedge i_clk);
    chk("irq cleared", irq, 1'b0);
    $display("test interrupt done");
    end_sim();
  end
endmodule : tb

// ==== thresh_if.sv ====
// carrier between the control register and the level comparator
`timescale 1ns/1ps
interface thresh_if #(
  parameter int COUNT_W = 5
);
  logic [COUNT_W-1:0] rx_count;
  logic [2:0]         flow_sel;
  logic [1:0]         trig_sel;
  logic               sync_mode;
  logic               over_flow;
  logic               over_trig;

  modport ctrl (output rx_count, flow_sel, trig_sel, sync_mode, input over_flow, over_trig);
  modport cmp  (input rx_count, flow_sel, trig_sel, sync_mode, output over_flow, over_trig);
endinterface : thresh_if

// ==== threshold_compare.sv ====
// decodes the two threshold fields and compares the receive fill count
`timescale 1ns/1ps
`include "fifo_thresh_map.svh"
module threshold_compare
  import fifo_thresh_pkg::*;
#(
  parameter int COUNT_W = 5
) (
  thresh_if.cmp th
);

  logic [COUNT_W-1:0] flow_lvl;
  logic [COUNT_W-1:0] trig_lvl;

  always_comb begin
    case (th.flow_sel)
      3'h0:    flow_lvl = COUNT_W'(`FLOW_LVL_0);
      3'h1:    flow_lvl = COUNT_W'(`FLOW_LVL_1);
      3'h2:    flow_lvl = COUNT_W'(`FLOW_LVL_2);
      3'h3:    flow_lvl = COUNT_W'(`FLOW_LVL_3);
      3'h4:    flow_lvl = COUNT_W'(`FLOW_LVL_4);
      3'h5:    flow_lvl = COUNT_W'(`FLOW_LVL_5);
      3'h6:    flow_lvl = COUNT_W'(`FLOW_LVL_6);
      default: flow_lvl = COUNT_W'(`FLOW_LVL_7);
    endcase
    case (th.trig_sel)
      2'h0:    trig_lvl = COUNT_W'(`ASYNC_LVL_0);
      2'h1:    trig_lvl = th.sync_mode ? COUNT_W'(`SYNC_LVL_1)
                                       : COUNT_W'(`ASYNC_LVL_1);
      2'h2:    trig_lvl = COUNT_W'(`ASYNC_LVL_2);
      default: trig_lvl = COUNT_W'(`ASYNC_LVL_3);
    endcase
  end

  assign th.over_flow = th.rx_count > flow_lvl;
  assign th.over_trig = th.rx_count > trig_lvl;

endmodule : threshold_compare
